// ==== design/fewc_flash_ctrl.sv ====
// Purpose: flash erase and write control reached through sfr registers
// Assumes: sfr writes and movx strobes are one-cycle pulses on clk
// Notes: flash timing itself lives in the flash macro
`timescale 1ns/1ps
`default_nettype none
module fewc_flash_ctrl #(
  parameter int AW = fewc_pkg::FLASH_AW,
  parameter int DW = fewc_pkg::DATA_W
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // sfr bus
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  // processor status
  input wire logic irq_enabled,
  input wire logic emulator_debug_port,
  // movx to program space
  input wire logic movx_wr,
  input wire logic [AW-1:0] movx_addr,
  input wire logic [DW-1:0] movx_data,
  // computation engine
  input wire logic engine_enable,
  input wire logic engine_busy,
  // flash array
  output logic page_erase_go,
  output logic [fewc_pkg::PAGE_W-1:0] page_erase_page,
  output logic mass_erase_go,
  output logic flash_wr_go,
  output logic [AW-1:0] flash_wr_addr,
  output logic [DW-1:0] flash_wr_data
);
  // ****************************************
  // decode helpers
  // ****************************************
  // one compare shape for every sfr hit
  function automatic logic sfr_hit(
    input logic strobe,
    input logic [7:0] addr,
    input logic [7:0] target
  );
    return strobe && (addr == target);
  endfunction

  // field reaches 127 but pages stop at 63, so clamp
  function automatic logic [fewc_pkg::PAGE_W-1:0] page_field(
    input logic [7:0] data
  );
    logic [fewc_pkg::PAGE_W-1:0] raw;
    raw = data[fewc_pkg::PAGE_LSB +: fewc_pkg::PAGE_W];
    if (raw > fewc_pkg::PAGE_MAX) begin
      raw = fewc_pkg::PAGE_MAX;
    end
    return raw;
  endfunction

  // arm bit is write-only, reads as zero
  function automatic logic [7:0] ctl_word(
    input logic prog_we,
    input logic defer_en,
    input logic pending
  );
    logic [7:0] word;
    word = '0;
    word[fewc_pkg::BIT_PROG_WE] = prog_we;
    word[fewc_pkg::BIT_DEFER_EN] = defer_en;
    word[fewc_pkg::BIT_PENDING] = pending;
    return word;
  endfunction

  // ****************************************
  // register state
  // ****************************************
  logic prog_we_q;
  logic mass_arm_q;
  logic defer_en_q;
  logic [fewc_pkg::PAGE_W-1:0] page_idx_q;
  logic pend;
  logic hold_go;
  logic [AW-1:0] hold_addr;
  logic [DW-1:0] hold_data;
  logic wr_ctl;
  logic wr_cmd;
  logic wr_page;
  logic movx_take;

  assign wr_ctl = sfr_hit(sfr_wr, sfr_addr, fewc_pkg::ADDR_FLASH_CTL);
  assign wr_cmd = sfr_hit(sfr_wr, sfr_addr, fewc_pkg::ADDR_ERASE_CMD);
  assign wr_page = sfr_hit(sfr_wr, sfr_addr, fewc_pkg::ADDR_PAGE_IDX);
  assign movx_take = movx_wr && prog_we_q;

  // a movx in the same cycle as a software write wins, so the bit cannot re-arm
  always_ff @(posedge clk) begin
    if (rst) begin
      prog_we_q <= 1'b0;
    end else if (ce) begin
      if (movx_take) begin
        prog_we_q <= 1'b0;
      end else if (wr_ctl && !irq_enabled) begin
        prog_we_q <= sfr_wdata[fewc_pkg::BIT_PROG_WE];
      end
    end
  end

  // arm is consumed by any erase command so it never carries over
  always_ff @(posedge clk) begin
    if (rst) begin
      mass_arm_q <= 1'b0;
    end else if (ce) begin
      if (wr_cmd) begin
        mass_arm_q <= 1'b0;
      end else if (wr_ctl) begin
        mass_arm_q <= sfr_wdata[fewc_pkg::BIT_MASS_ARM];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      defer_en_q <= 1'b0;
    end else if (ce && wr_ctl) begin
      defer_en_q <= sfr_wdata[fewc_pkg::BIT_DEFER_EN];
    end
  end

  // index stays after an erase; software rewrites it each time
  always_ff @(posedge clk) begin
    if (rst) begin
      page_idx_q <= fewc_pkg::PAGE_RESET;
    end else if (ce && wr_page) begin
      page_idx_q <= page_field(sfr_wdata);
    end
  end

  // ****************************************
  // erase commands
  // ****************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      page_erase_go <= 1'b0;
      mass_erase_go <= 1'b0;
      page_erase_page <= fewc_pkg::PAGE_RESET;
    end else if (ce) begin
      page_erase_go <= 1'b0;
      mass_erase_go <= 1'b0;
      if (wr_cmd) begin
        if (sfr_wdata == fewc_pkg::CMD_PAGE_ERASE) begin
          page_erase_go <= 1'b1;
          page_erase_page <= page_idx_q;
        end else if (sfr_wdata == fewc_pkg::CMD_MASS_ERASE) begin
          mass_erase_go <= mass_arm_q && emulator_debug_port;
        end
        // any other code leaves both pulses low
      end
    end
  end

  // ****************************************
  // flash writes
  // ****************************************
  // a held write leaves only on a busy fall, even if the engine is switched off
  fewc_write_holder #(
    .AW(AW),
    .DW(DW)
  ) u_holder (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .req_valid(movx_take),
    .defer(defer_en_q && engine_enable),
    .req_addr(movx_addr),
    .req_data(movx_data),
    .engine_busy(engine_busy),
    .wr_go(hold_go),
    .wr_addr(hold_addr),
    .wr_data(hold_data),
    .pending(pend)
  );

  always_ff @(posedge clk) begin
    if (rst) begin
      flash_wr_go <= 1'b0;
      flash_wr_addr <= '0;
      flash_wr_data <= '0;
    end else if (ce) begin
      flash_wr_go <= hold_go;
      if (hold_go) begin
        flash_wr_addr <= hold_addr;
        flash_wr_data <= hold_data;
      end
    end
  end

  // ****************************************
  // read back
  // ****************************************
  // other addresses read as zero
  always_ff @(posedge clk) begin
    if (rst) begin
      sfr_rdata <= '0;
    end else if (ce) begin
      if (sfr_hit(1'b1, sfr_addr, fewc_pkg::ADDR_FLASH_CTL)) begin
        sfr_rdata <= ctl_word(prog_we_q, defer_en_q, pend);
      end else begin
        sfr_rdata <= '0;
      end
    end
  end
endmodule
`default_nettype wire

// ==== design/fewc_pkg.sv ====
// Purpose: constants for the flash erase/write control block
// Assumes: sfr bus with 8-bit address and data, processor clock domain
// Notes: offsets are sfr addresses
package fewc_pkg;
  localparam logic [7:0] ADDR_ERASE_CMD = 8'h94;
  localparam logic [7:0] ADDR_FLASH_CTL = 8'hb2;
  localparam logic [7:0] ADDR_PAGE_IDX = 8'hb7;
  localparam logic [7:0] CMD_PAGE_ERASE = 8'h55;
  localparam logic [7:0] CMD_MASS_ERASE = 8'haa;
  // bit positions in the control register at 0xb2
  localparam int BIT_PROG_WE = 0;
  localparam int BIT_MASS_ARM = 1;
  localparam int BIT_DEFER_EN = 2;
  localparam int BIT_PENDING = 3;
  // page index sits in bits 7:1 of its register
  localparam int PAGE_LSB = 1;
  localparam int PAGE_W = 7;
  localparam logic [6:0] PAGE_RESET = 7'h00;
  localparam logic [6:0] PAGE_MAX = 7'h3f;
  localparam int FLASH_AW = 17;
  localparam int DATA_W = 8;
endpackage

// ==== design/fewc_write_holder.sv ====
// Purpose: single-entry holder for deferred flash writes
// Assumes: engine busy is synchronous to clk
// Notes: releases the held write on the falling edge of busy
`timescale 1ns/1ps
`default_nettype none
module fewc_write_holder #(
  parameter int AW = 17,
  parameter int DW = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // request side
  input wire logic req_valid,
  input wire logic defer,
  input wire logic [AW-1:0] req_addr,
  input wire logic [DW-1:0] req_data,
  input wire logic engine_busy,
  // flash side
  output logic wr_go,
  output logic [AW-1:0] wr_addr,
  output logic [DW-1:0] wr_data,
  output logic pending
);
  logic busy_q;
  logic held_q;
  logic [AW-1:0] addr_q;
  logic [DW-1:0] data_q;
  logic busy_fall;
  logic accept;

  assign busy_fall = busy_q && !engine_busy;
  // a request while one is held is dropped
  assign accept = req_valid && !held_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      busy_q <= 1'b0;
    end else if (ce) begin
      busy_q <= engine_busy;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      held_q <= 1'b0;
      addr_q <= '0;
      data_q <= '0;
    end else if (ce) begin
      if (accept && defer) begin
        held_q <= 1'b1;
        addr_q <= req_addr;
        data_q <= req_data;
      end else if (held_q && busy_fall) begin
        held_q <= 1'b0;
      end
    end
  end

  always_comb begin
    wr_go = 1'b0;
    wr_addr = req_addr;
    wr_data = req_data;
    if (held_q && busy_fall) begin
      wr_go = 1'b1;
      wr_addr = addr_q;
      wr_data = data_q;
    end else if (accept && !defer) begin
      wr_go = 1'b1;
    end
  end

  assign pending = held_q;
endmodule
`default_nettype wire

// ==== sim/fewc_flash_ctrl_sva.sv ====
// Purpose: port-level checks for the flash erase/write control
// Assumes: checks pause while ce is low
// Notes: shadow bits track which movx writes must reach flash
`timescale 1ns/1ps
`default_nettype none
module fewc_flash_ctrl_sva #(parameter int AW = 17, parameter int DW = 8) (
  // clock, sfr and status
  input wire logic clk, rst, ce, sfr_wr, irq_enabled, emulator_debug_port,
  input wire logic [7:0] sfr_addr, sfr_wdata,
  // movx and engine
  input wire logic movx_wr, engine_enable, engine_busy,
  input wire logic [AW-1:0] movx_addr,
  input wire logic [DW-1:0] movx_data,
  // flash side
  input wire logic page_erase_go, mass_erase_go, flash_wr_go,
  input wire logic [6:0] page_erase_page,
  input wire logic [AW-1:0] flash_wr_addr,
  input wire logic [DW-1:0] flash_wr_data
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst || !ce);
  logic pwe_q, def_q, pnd_q, arm_q;
  // not a full model: only what decides whether a write or erase must go out
  always_ff @(posedge clk) begin
    if (rst) begin
      pwe_q <= 1'b0;
      def_q <= 1'b0;
      pnd_q <= 1'b0;
      arm_q <= 1'b0;
    end else if (ce) begin
      if (movx_wr) pwe_q <= 1'b0;
      else if (sfr_wr && sfr_addr == 8'hb2 && !irq_enabled) pwe_q <= sfr_wdata[0];
      if (sfr_wr && sfr_addr == 8'hb2) def_q <= sfr_wdata[2];
      if (flash_wr_go) pnd_q <= 1'b0;
      else if (movx_wr && pwe_q && def_q && engine_enable) pnd_q <= 1'b1;
      if (sfr_wr && sfr_addr == 8'h94) arm_q <= 1'b0;
      else if (sfr_wr && sfr_addr == 8'hb2) arm_q <= sfr_wdata[1];
    end
  end
  sequence cmd_s(logic [7:0] c);
    sfr_wr && sfr_addr == 8'h94 && sfr_wdata == c;
  endsequence
  chk_page_go: assert property (cmd_s(8'h55) |=> page_erase_go) else $error("no page erase");
  chk_mass_go: assert property ((arm_q && emulator_debug_port) ##0 cmd_s(8'haa) |=> mass_erase_go)
    else $error("no mass erase");
  chk_page_range: assert property (page_erase_go |-> page_erase_page <= 7'h3f) else $error("bad page");
  chk_page_cause: assert property (page_erase_go |->
    $past(sfr_wr && sfr_addr == 8'h94 && sfr_wdata == 8'h55)) else $error("stray page erase");
  chk_mass_cause: assert property (mass_erase_go |->
    $past(sfr_wr && sfr_addr == 8'h94 && sfr_wdata == 8'haa && emulator_debug_port)) else $error("stray mass");
  chk_imm_write: assert property (movx_wr && pwe_q && !pnd_q && !(def_q && engine_enable) |=>
    flash_wr_go && flash_wr_addr == $past(movx_addr) && flash_wr_data == $past(movx_data)) else $error("no write");
  chk_defer_hold: assert property (movx_wr && pwe_q && !pnd_q && def_q && engine_enable |=> !flash_wr_go)
    else $error("write not held");
  chk_pend_drop: assert property (movx_wr && pnd_q && engine_busy |=> !flash_wr_go) else $error("not dropped");
  chk_nowe_drop: assert property (movx_wr && !pwe_q && !pnd_q |=> !flash_wr_go) else $error("write no pwe");
  chk_write_cause: assert property (flash_wr_go |->
    $past(movx_wr) || ($past(engine_busy, 2) && !$past(engine_busy))) else $error("stray write");
endmodule
bind fewc_flash_ctrl fewc_flash_ctrl_sva #(.AW(AW), .DW(DW)) u_sva (.clk(clk), .rst(rst), .ce(ce), .sfr_wr(sfr_wr),
  .irq_enabled(irq_enabled), .emulator_debug_port(emulator_debug_port), .sfr_addr(sfr_addr),
  .sfr_wdata(sfr_wdata), .movx_wr(movx_wr), .engine_enable(engine_enable), .engine_busy(engine_busy),
  .movx_addr(movx_addr), .movx_data(movx_data), .page_erase_go(page_erase_go), .mass_erase_go(mass_erase_go),
  .flash_wr_go(flash_wr_go), .page_erase_page(page_erase_page), .flash_wr_addr(flash_wr_addr),
  .flash_wr_data(flash_wr_data));
`default_nettype wire

// ==== sim/fewc_flash_ctrl_tb.sv ====
// Purpose: self-checking bench for the flash erase/write control
// Assumes: ce high except in one frozen window
// Notes: expected flash events are queued by the bench model
`timescale 1ns/1ps
`default_nettype none
module fewc_flash_ctrl_tb;
  logic clk = 0, rst = 1, ce = 1, wr = 0, irq = 0, dbg = 0, mv = 0, ee = 0, bz = 0;
  logic [7:0] ad = 0, dt = 0, md = 0, rd, wdo;
  logic [16:0] ma = 0, wa;
  logic pe, me, wg, pwe = 0, def = 0, pend = 0;
  logic [6:0] pg;
  logic [31:0] hold, ex[$];
  int failures = 0, cmp_count = 0, s = 15485, p, i;
  initial forever #10 clk = ~clk;
  fewc_flash_ctrl dut (.clk(clk), .rst(rst), .ce(ce), .sfr_wr(wr), .sfr_addr(ad), .sfr_wdata(dt), .sfr_rdata(rd),
    .irq_enabled(irq), .emulator_debug_port(dbg), .movx_wr(mv), .movx_addr(ma), .movx_data(md),
    .engine_enable(ee), .engine_busy(bz), .page_erase_go(pe), .page_erase_page(pg), .mass_erase_go(me),
    .flash_wr_go(wg), .flash_wr_addr(wa), .flash_wr_data(wdo));
  fewc_flash_model fm (.clk(clk), .rst(rst), .pe(pe), .me(me), .wg(wg), .pg(pg), .wd({wa, wdo}));
  function int xs();
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task ck(input string n, input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task sw(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) #1;
    wr = 1; ad = a; dt = d;
    if (a == 8'hb2 && !irq) pwe = d[0];
    if (a == 8'hb2) def = d[2];
    @(posedge clk) #1;
    wr = 0;
  endtask
  task mx();
    @(posedge clk) #1;
    mv = 1; ma = 17'(xs()); md = 8'(xs());
    if (pwe && !pend && def && ee) begin
      pend = 1;
      hold = {7'h8, ma, md};
    end else if (pwe && !pend) ex.push_back({7'h8, ma, md});
    pwe = 0;
    @(posedge clk) #1;
    mv = 0;
  endtask
  task rb(input logic [7:0] e);
    @(posedge clk) #1;
    ad = 8'hb2;
    @(posedge clk) #1;
    ck("ctl read", {24'h0, rd & 8'h0f}, {24'h0, e});
  endtask
  task fl();
    repeat (4) @(posedge clk);
    #1 ck("event count", fm.ev.size(), ex.size());
    while (ex.size() > 0 && fm.ev.size() > 0) ck("event", fm.ev.pop_front(), ex.pop_front());
    fm.ev.delete();
    ex.delete();
  endtask
  task test_done();
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // ************************************************************
  // scenarios
  // ************************************************************
  initial begin
    repeat (20) @(posedge clk);
    #1 rst = 0;
    rb(8'h00);
    for (i = 0; i < 6; i++) begin
      p = (i == 0) ? 63 : (i == 1) ? 127 : xs() & 63;
      sw(8'hb7, 8'(p << 1));
      sw(8'h94, 8'h55);
      ex.push_back({25'h2, 7'(p > 63 ? 63 : p)});
    end
    fl();
    for (i = 0; i < 6; i++) begin
      p = (i < 2) ? i * 255 : xs() & 255;
      sw(8'h94, (p == 8'h55 || p == 8'haa) ? 8'h54 : 8'(p));
    end
    ce = 0;
    sw(8'h94, 8'h55);
    ce = 1;
    fl();
    sw(8'h94, 8'haa);
    sw(8'hb2, 8'h02);
    sw(8'h94, 8'haa);
    dbg = 1;
    sw(8'hb2, 8'h02);
    sw(8'h94, 8'haa);
    ex.push_back(32'h200);
    sw(8'h94, 8'haa);
    fl();
    irq = 1;
    sw(8'hb2, 8'h01);
    mx();
    irq = 0;
    for (i = 0; i < 2; i++) begin
      sw(8'hb2, (i == 0) ? 8'h01 : 8'h05);
      mx();
      mx();
    end
    fl();
    ee = 1;
    bz = 1;
    sw(8'hb2, 8'h05);
    mx();
    rb(8'h0c);
    sw(8'hb2, 8'h05);
    mx();
    fl();
    bz = 0;
    ex.push_back(hold);
    pend = 0;
    fl();
    rb(8'h04);
    sw(8'hb2, 8'h01);
    mx();
    fl();
    test_done();
  end
  // run is about 130 cycles; this only catches a hang
  initial begin
    #100us;
    failures++;
    test_done();
  end
endmodule
`default_nettype wire

// ==== sim/fewc_flash_model.sv ====
// Purpose: flash array stand-in that logs erase and write pulses
// Assumes: each pulse lasts one clk
// Notes: the bench pops the log
`timescale 1ns/1ps
`default_nettype none
module fewc_flash_model (
  // flash pulses
  input wire logic clk, rst, pe, me, wg,
  input wire logic [6:0] pg,
  input wire logic [24:0] wd
);
  logic [31:0] ev[$];
  always @(posedge clk) begin
    if (!rst && pe) ev.push_back({25'h2, pg});
    if (!rst && me) ev.push_back(32'h200);
    if (!rst && wg) ev.push_back({7'h8, wd});
  end
endmodule
`default_nettype wire
